// ===== verilog/crma_core.sv
// Call/return stack, ROM bank control and memory ALU behind a Wishbone slave.
// Assumes a classic Wishbone master on clk_i; all inputs are on that clock.
//
// Contract
// - A call is taken only while the condition flag is 1, otherwise the counter just steps.
// - A skipped call changes no stack or bank register and sets the flag back to 1.
// - A taken call loads the operand address and pushes the next address into level one.
// - Return stack and bank save stack are three levels deep and lose the oldest entry.
// - The program counter steps through a fixed pseudo-random sequence.
// - A return loads the counter from level one and shifts up, keeping the deepest level.
// - A return loads both banks from bank save level one, shifts it up and sets the flag.
// - Load-bank writes its immediate into the next bank only and sets the flag.
// - The next bank captures three bits of the six-bit immediate.
// - Add puts the 4-bit sum of memory and accumulator in the accumulator, flag is carry.
// - Add writes the accumulator and flag and steps the counter, never the RAM.
// - Subtract puts memory minus accumulator in the accumulator, flag set if acc <= mem.
// - Increment puts memory plus one in the accumulator, flag set when the word was 15.
// - Memory operands are the word selected by page index and word pointer.
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`default_nettype none

module crma_core
    import crma_pkg::*;
#(
    parameter int PC_W = 6,
    parameter int BANK_W = 3,
    parameter int PAGE_W = 2,
    parameter int WORD_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [PC_W-1:0] pc_o,
    output logic [3:0] acc_o,
    output logic condition_flag_o,
    output logic [BANK_W-1:0] active_rom_bank_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    crma_state_t state_ff;
    logic ack_ff, condition_flag_ff;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [3:0] op_ff, acc_ff, mem_word;
    logic [PC_W-1:0] arg_ff, pc_ff, pc_step;
    logic [PC_W-1:0] return_level_one_ff, return_level_two_ff, return_level_three_ff;
    logic [BANK_W-1:0] active_rom_bank_ff, next_rom_bank_ff;
    logic [BANK_W-1:0] bank_save_level_one_ff, bank_save_level_two_ff;
    logic [BANK_W-1:0] bank_save_level_three_ff;
    logic [PAGE_W-1:0] page_ff;
    logic [WORD_W-1:0] word_ff;
    logic req, wr_ok, exec, call_taken, call_skip, do_ret, do_ldb;
    logic do_add, do_sub, do_inc;
    logic [4:0] sum_add, sum_sub, sum_inc;
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    crma_pc_seq #(.PC_W(PC_W)) u_pc_seq (
        .pc_i(pc_ff),
        .pc_next_o(pc_step)
    );
    crma_ram #(.PAGE_W(PAGE_W), .WORD_W(WORD_W)) u_ram (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_ok && wb_adr_i == REG_RAM_DATA),
        .page_i(page_ff),
        .word_i(word_ff),
        .wdata_i(wb_dat_i[3:0]),
        .rdata_o(mem_word)
    );
    // ------------------------------------------------------------------
    // Bus decode and instruction decode
    // ------------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i && !ack_ff && state_ff == CRMA_IDLE;
    assign wr_ok = req && wb_we_i && wb_sel_i == 4'hf;
    assign exec = state_ff == CRMA_EXEC;
    assign call_taken = exec && op_ff == OP_COND_CALL && condition_flag_ff;
    assign call_skip = exec && op_ff == OP_COND_CALL && !condition_flag_ff;
    assign do_ret = exec && op_ff == OP_SUBROUTINE_RETURN;
    assign do_ldb = exec && op_ff == OP_LOAD_BANK_BUFFER;
    assign do_add = exec && op_ff == OP_ADD_MEMORY;
    assign do_sub = exec && op_ff == OP_SUBTRACT_FROM_MEMORY;
    assign do_inc = exec && op_ff == OP_INCREMENT_MEMORY;
    // Carry out of bit 3 lands in bit 4 and goes only to the flag
    assign sum_add = crma_add5(mem_word, acc_ff, 1'b0);
    assign sum_sub = crma_add5(mem_word, ~acc_ff, 1'b1);
    assign sum_inc = crma_add5(mem_word, 4'h0, 1'b1);
    always_comb begin
        nxt_rdata = RST_RDATA;
        case (wb_adr_i)
            REG_CMD: begin
                nxt_rdata[CMD_OP_LSB +: 4] = op_ff;
                nxt_rdata[CMD_ARG_LSB +: PC_W] = arg_ff;
            end
            REG_ACC: nxt_rdata[3:0] = acc_ff;
            REG_STATUS: begin
                nxt_rdata[STAT_FLAG_BIT] = condition_flag_ff;
                nxt_rdata[STAT_ACTIVE_LSB +: BANK_W] = active_rom_bank_ff;
                nxt_rdata[STAT_NEXT_LSB +: BANK_W] = next_rom_bank_ff;
            end
            REG_PC: nxt_rdata[PC_W-1:0] = pc_ff;
            REG_RET_STACK: begin
                nxt_rdata[LVL_ONE_LSB +: PC_W] = return_level_one_ff;
                nxt_rdata[LVL_TWO_LSB +: PC_W] = return_level_two_ff;
                nxt_rdata[LVL_THREE_LSB +: PC_W] = return_level_three_ff;
            end
            REG_BANK_STACK: begin
                nxt_rdata[LVL_ONE_LSB +: BANK_W] = bank_save_level_one_ff;
                nxt_rdata[LVL_TWO_LSB +: BANK_W] = bank_save_level_two_ff;
                nxt_rdata[LVL_THREE_LSB +: BANK_W] = bank_save_level_three_ff;
            end
            REG_RAM_INDEX: begin
                nxt_rdata[IDX_WORD_LSB +: WORD_W] = word_ff;
                nxt_rdata[IDX_PAGE_LSB +: PAGE_W] = page_ff;
            end
            REG_RAM_DATA: nxt_rdata[3:0] = mem_word;
            default: nxt_rdata = RST_RDATA;
        endcase
    end
    // ------------------------------------------------------------------
    // Wishbone slave: one wait-free answer per request
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= RST_RDATA;
        end else begin
            ack_ff <= req;
            if (req) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end
    // ------------------------------------------------------------------
    // Command capture and execution sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= CRMA_IDLE;
            op_ff <= OP_STEP;
            arg_ff <= '0;
        end else begin
            case (state_ff)
                CRMA_IDLE: begin
                    if (wr_ok && wb_adr_i == REG_CMD) begin
                        op_ff <= wb_dat_i[CMD_OP_LSB +: 4];
                        arg_ff <= wb_dat_i[CMD_ARG_LSB +: PC_W];
                        state_ff <= CRMA_EXEC;
                    end
                end
                CRMA_EXEC: state_ff <= CRMA_IDLE;
                default: state_ff <= CRMA_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_ff <= '0;
        end else if (call_taken) begin
            pc_ff <= arg_ff;
        end else if (do_ret) begin
            pc_ff <= return_level_one_ff;
        end else if (exec) begin
            pc_ff <= pc_step;
        end else if (wr_ok && wb_adr_i == REG_PC) begin
            pc_ff <= wb_dat_i[PC_W-1:0];
        end
    end
    // ------------------------------------------------------------------
    // Return address stack
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            return_level_one_ff <= '0;
            return_level_two_ff <= '0;
            return_level_three_ff <= '0;
        end else if (call_taken) begin
            return_level_one_ff <= pc_step;
            return_level_two_ff <= return_level_one_ff;
            return_level_three_ff <= return_level_two_ff;
        end else if (do_ret) begin
            return_level_one_ff <= return_level_two_ff;
            return_level_two_ff <= return_level_three_ff;
        end
    end
    // ------------------------------------------------------------------
    // ROM bank registers and bank save stack
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_rom_bank_ff <= '0;
            next_rom_bank_ff <= '0;
            bank_save_level_one_ff <= '0;
            bank_save_level_two_ff <= '0;
            bank_save_level_three_ff <= '0;
        end else if (call_taken) begin
            active_rom_bank_ff <= next_rom_bank_ff;
            bank_save_level_one_ff <= active_rom_bank_ff;
            bank_save_level_two_ff <= bank_save_level_one_ff;
            bank_save_level_three_ff <= bank_save_level_two_ff;
        end else if (do_ret) begin
            active_rom_bank_ff <= bank_save_level_one_ff;
            next_rom_bank_ff <= bank_save_level_one_ff;
            bank_save_level_one_ff <= bank_save_level_two_ff;
            bank_save_level_two_ff <= bank_save_level_three_ff;
        end else if (do_ldb) begin
            next_rom_bank_ff <= arg_ff[BANK_W-1:0];
        end
    end
    // ------------------------------------------------------------------
    // Accumulator and condition flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff <= RST_ACC;
            condition_flag_ff <= RST_FLAG;
        end else if (do_add) begin
            acc_ff <= sum_add[3:0];
            condition_flag_ff <= sum_add[4];
        end else if (do_sub) begin
            acc_ff <= sum_sub[3:0];
            condition_flag_ff <= sum_sub[4];
        end else if (do_inc) begin
            acc_ff <= sum_inc[3:0];
            condition_flag_ff <= sum_inc[4];
        end else if (exec) begin
            condition_flag_ff <= 1'b1;
        end else if (wr_ok && wb_adr_i == REG_ACC) begin
            acc_ff <= wb_dat_i[3:0];
        end
    end
    // ------------------------------------------------------------------
    // RAM index registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_ff <= '0;
            word_ff <= '0;
        end else if (wr_ok && wb_adr_i == REG_RAM_INDEX) begin
            word_ff <= wb_dat_i[IDX_WORD_LSB +: WORD_W];
            page_ff <= wb_dat_i[IDX_PAGE_LSB +: PAGE_W];
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign pc_o = pc_ff;
    assign acc_o = acc_ff;
    assign condition_flag_o = condition_flag_ff;
    assign active_rom_bank_o = active_rom_bank_ff;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_call_taken;
        @(posedge clk_i) disable iff (rst_i)
        call_taken |=> pc_ff == $past(arg_ff) && return_level_one_ff == $past(pc_step)
            && return_level_two_ff == $past(return_level_one_ff)
            && return_level_three_ff == $past(return_level_two_ff);
    endproperty
    a_call_taken: assert property (p_call_taken) else $error("taken call push wrong");
    property p_call_skip;
        @(posedge clk_i) disable iff (rst_i)
        call_skip |=> pc_ff == $past(pc_step) && condition_flag_ff
            && $stable(return_level_one_ff) && $stable(active_rom_bank_ff)
            && $stable(bank_save_level_one_ff);
    endproperty
    a_call_skip: assert property (p_call_skip) else $error("skipped call changed state");
    property p_call_bank;
        @(posedge clk_i) disable iff (rst_i)
        call_taken |=> active_rom_bank_ff == $past(next_rom_bank_ff)
            && bank_save_level_one_ff == $past(active_rom_bank_ff)
            && bank_save_level_three_ff == $past(bank_save_level_two_ff);
    endproperty
    a_call_bank: assert property (p_call_bank) else $error("call bank push wrong");
    property p_return;
        @(posedge clk_i) disable iff (rst_i)
        do_ret |=> pc_ff == $past(return_level_one_ff)
            && return_level_two_ff == $past(return_level_three_ff)
            && $stable(return_level_three_ff);
    endproperty
    a_return: assert property (p_return) else $error("return pop wrong");
    property p_return_bank;
        @(posedge clk_i) disable iff (rst_i)
        do_ret |=> active_rom_bank_ff == $past(bank_save_level_one_ff)
            && next_rom_bank_ff == $past(bank_save_level_one_ff) && condition_flag_ff;
    endproperty
    a_return_bank: assert property (p_return_bank) else $error("return bank wrong");
    property p_load_bank;
        @(posedge clk_i) disable iff (rst_i)
        do_ldb |=> next_rom_bank_ff == $past(arg_ff[BANK_W-1:0])
            && $stable(active_rom_bank_ff) && condition_flag_ff;
    endproperty
    a_load_bank: assert property (p_load_bank) else $error("load bank wrong");
    property p_add;
        @(posedge clk_i) disable iff (rst_i)
        do_add |=> {condition_flag_ff, acc_ff} == {1'b0, $past(mem_word)} + {1'b0, $past(acc_ff)}
            && $stable(mem_word);
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");
    property p_sub;
        @(posedge clk_i) disable iff (rst_i)
        do_sub |=> acc_ff == 4'($past(mem_word) - $past(acc_ff))
            && condition_flag_ff == ($past(acc_ff) <= $past(mem_word));
    endproperty
    a_sub: assert property (p_sub) else $error("subtract result wrong");
    property p_inc;
        @(posedge clk_i) disable iff (rst_i)
        do_inc |=> acc_ff == 4'($past(mem_word) + 4'h1)
            && condition_flag_ff == ($past(mem_word) == WORD_MAX);
    endproperty
    a_inc: assert property (p_inc) else $error("increment result wrong");
    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer not one cycle");
    c_call: cover property (@(posedge clk_i) disable iff (rst_i) call_taken);
    c_skip: cover property (@(posedge clk_i) disable iff (rst_i) call_skip);
    c_ret: cover property (@(posedge clk_i) disable iff (rst_i) do_ret);
    c_carry: cover property (@(posedge clk_i) disable iff (rst_i) do_add && sum_add[4]);
endmodule

`default_nettype wire

// ===== verilog/crma_pkg.sv
// Constants, opcodes and states shared by the call/return and memory ALU block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`default_nettype none

package crma_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0c;
    localparam logic [7:0] REG_RET_STACK = 8'h10;
    localparam logic [7:0] REG_BANK_STACK = 8'h14;
    localparam logic [7:0] REG_RAM_INDEX = 8'h18;
    localparam logic [7:0] REG_RAM_DATA = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ARG_LSB = 4;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_ACTIVE_LSB = 4;
    localparam int STAT_NEXT_LSB = 8;
    localparam int LVL_ONE_LSB = 0;
    localparam int LVL_TWO_LSB = 8;
    localparam int LVL_THREE_LSB = 16;
    localparam int IDX_WORD_LSB = 0;
    localparam int IDX_PAGE_LSB = 4;

    // ------------------------------------------------------------------
    // Reset values and word limit
    // ------------------------------------------------------------------
    localparam logic RST_FLAG = 1'b1;
    localparam logic [3:0] RST_ACC = 4'h0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    localparam logic [3:0] WORD_MAX = 4'hf;

    // ------------------------------------------------------------------
    // Opcodes written into the command register
    // ------------------------------------------------------------------
    localparam logic [3:0] OP_STEP = 4'h0;
    localparam logic [3:0] OP_COND_CALL = 4'h1;
    localparam logic [3:0] OP_SUBROUTINE_RETURN = 4'h2;
    localparam logic [3:0] OP_LOAD_BANK_BUFFER = 4'h3;
    localparam logic [3:0] OP_ADD_MEMORY = 4'h4;
    localparam logic [3:0] OP_SUBTRACT_FROM_MEMORY = 4'h5;
    localparam logic [3:0] OP_INCREMENT_MEMORY = 4'h6;

    typedef enum logic [1:0] {
        CRMA_IDLE = 2'b01,
        CRMA_EXEC = 2'b10
    } crma_state_t;

    // Four-bit add with carry in, carry out in bit 4
    function automatic logic [4:0] crma_add5(input logic [3:0] a, input logic [3:0] b,
                                             input logic cin);
        return {1'b0, a} + {1'b0, b} + {4'h0, cin};
    endfunction

endpackage

`default_nettype wire

// ===== verilog/crma_pc_seq.sv
// Next-address generator for the program counter.
// Assumes the counter is held elsewhere; this is purely combinational.
`default_nettype none

module crma_pc_seq #(
    parameter int PC_W = 6
) (
    input wire logic [PC_W-1:0] pc_i,
    output logic [PC_W-1:0] pc_next_o
);

    // ------------------------------------------------------------------
    // Shift-register sequence; the all-ones code is never reached from reset
    // ------------------------------------------------------------------
    always_comb begin
        pc_next_o = {pc_i[PC_W-2:0], ~(pc_i[PC_W-1] ^ pc_i[PC_W-2])};
    end

endmodule

`default_nettype wire

// ===== verilog/crma_ram.sv
// Nibble-wide data RAM indexed by page and word pointer.
// Assumes one write port driven from the register bus, asynchronous read.
`default_nettype none

module crma_ram #(
    parameter int PAGE_W = 2,
    parameter int WORD_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [PAGE_W-1:0] page_i,
    input wire logic [WORD_W-1:0] word_i,
    input wire logic [3:0] wdata_i,
    output logic [3:0] rdata_o
);

    localparam int DEPTH = 1 << (PAGE_W + WORD_W);

    logic [3:0] mem_ff [DEPTH];
    logic [PAGE_W+WORD_W-1:0] index;

    assign index = {page_i, word_i};
    assign rdata_o = mem_ff[index];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= 4'h0;
            end
        end else if (we_i) begin
            mem_ff[index] <= wdata_i;
        end
    end

endmodule

`default_nettype wire

// ===== testbench/crma_host.sv
// Wishbone classic master standing in for software on the register bus.
// Assumes a slave that acks every request; only the bench watchdog ends a wait.
`default_nettype none

module crma_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
        sel_o = 4'hf;
    end

    // ------------------------------------------------------------------
    // One single cycle, held until ack is seen
    // ------------------------------------------------------------------
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= adr;
        dat_o <= wd;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released data does not keep its last value
        dat_o <= ~wd;
    endtask
endmodule

`default_nettype wire

// ===== testbench/crma_core_bench.sv
// Self-checking bench: commands and register accesses over the bus.
// Assumes crma_host as bus master and the package register map.
`default_nettype none

module crma_core_bench
    import crma_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, flag_o, flg;
    logic [3:0] sel, acc_o, acc, mem;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, rd;
    logic [5:0] pc_o, mpc, r1, r2, r3;
    logic [2:0] bank_o, b1, b2, b3, act, nb;
    int failures = 0;
    int checked = 0;

    always #2.5 clk_i = ~clk_i;

    crma_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    crma_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pc_o(pc_o), .acc_o(acc_o), .condition_flag_o(flag_o), .active_rom_bank_o(bank_o));

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    function automatic logic [5:0] nx(input logic [5:0] p);
        return {p[4:0], ~(p[5] ^ p[4])};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd);
        chk(what, exp, rd);
    endtask

    task automatic seta(input logic [3:0] v);
        wr(REG_ACC, {28'h0, v});
        acc = v;
    endtask

    task automatic stacks();
        rdc("ret", REG_RET_STACK, {10'h0, r3, 2'h0, r2, 2'h0, r1});
        rdc("bank", REG_BANK_STACK, {13'h0, b3, 5'h0, b2, 5'h0, b1});
        rdc("status", REG_STATUS, {21'h0, nb, 1'b0, act, 3'h0, flg});
    endtask

    // Issues a command, advances the reference model, checks the outputs
    task automatic cmd(input logic [3:0] op, input logic [5:0] arg);
        wr(REG_CMD, {22'h0, arg, op});
        case (op)
            4'h1: begin
                if (flg) begin
                    {r3, r2, r1} = {r2, r1, nx(mpc)};
                    {b3, b2, b1, act} = {b2, b1, act, nb};
                end
                mpc = flg ? arg : nx(mpc);
                flg = 1'b1;
            end
            4'h2: begin
                {mpc, r1, r2} = {r1, r2, r3};
                {act, nb, b1, b2} = {b1, b1, b2, b3};
                flg = 1'b1;
            end
            default: begin
                mpc = nx(mpc);
                flg = 1'b1;
                if (op == 4'h3) nb = arg[2:0];
                if (op == 4'h4) {flg, acc} = {1'b0, mem} + {1'b0, acc};
                if (op == 4'h5) {flg, acc} = {acc <= mem, mem - acc};
                if (op == 4'h6) {flg, acc} = {mem == 4'hf, mem + 4'h1};
            end
        endcase
        @(posedge clk_i);
        chk("pc", {26'h0, mpc}, {26'h0, pc_o});
        chk("acc", {28'h0, acc}, {28'h0, acc_o});
        chk("flag", {31'h0, flg}, {31'h0, flag_o});
        chk("active", {29'h0, act}, {29'h0, bank_o});
    endtask

    task automatic summarize();
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {mpc, r1, r2, r3, b1, b2, b3, act, nb, acc, mem} = '0;
        flg = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        stacks();
        cmd(4'h0, 6'h00);
        cmd(4'h0, 6'h00);
        cmd(4'h3, 6'h0d);
        for (int i = 0; i < 4; i++) begin
            cmd(4'h1, 6'h10 + 6'(i));
            stacks();
            cmd(4'h3, 6'(i));
        end
        for (int i = 0; i < 3; i++) begin
            cmd(4'h2, 6'h00);
            stacks();
        end
        wr(REG_RAM_INDEX, 32'h25);
        wr(REG_RAM_DATA, 32'h9);
        wr(REG_RAM_INDEX, 32'h26);
        wr(REG_RAM_DATA, 32'h3);
        wr(REG_RAM_INDEX, 32'h25);
        mem = 4'h9;
        seta(4'h8);
        cmd(4'h4, 6'h00);
        rdc("ram", REG_RAM_DATA, 32'h9);
        wr(REG_RAM_INDEX, 32'h26);
        rdc("ram_word6", REG_RAM_DATA, 32'h3);
        rdc("index", REG_RAM_INDEX, 32'h26);
        wr(REG_RAM_INDEX, 32'h25);
        rdc("acc_reg", REG_ACC, {28'h0, acc});
        seta(4'h3);
        cmd(4'h4, 6'h00);
        cmd(4'h1, 6'h3f);
        wr(REG_RET_STACK, 32'h0);
        stacks();
        seta(4'h9);
        cmd(4'h5, 6'h00);
        seta(4'ha);
        cmd(4'h5, 6'h00);
        cmd(4'h6, 6'h00);
        cmd(4'h7, 6'h00);
        wr(REG_RAM_DATA, 32'hf);
        mem = 4'hf;
        cmd(4'h6, 6'h00);
        host.sel_o <= 4'h1;
        wr(REG_ACC, 32'h5);
        host.sel_o <= 4'hf;
        rdc("acc_sel", REG_ACC, {28'h0, acc});
        wr(REG_PC, 32'h20);
        mpc = 6'h20;
        rdc("pc_reg", REG_PC, 32'h20);
        cmd(4'h0, 6'h2a);
        rdc("cmd_reg", REG_CMD, 32'h2a0);
        rdc("unmapped", 8'h40, 32'h0);
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        summarize();
    end
endmodule

`default_nettype wire
